// ==== src/oss_seq.v ====
`timescale 1ns/1ps
`include "oss_defs.vh"

// Notes on behaviour
// - cam-off: high speed, low on cam rise, fix on marker after cam release
// - cam-off: marker never fixes origin while cam is still active
// - cam-off: marker ignored during high-to-low deceleration
// - cam-on: high speed, decelerate to low speed on cam rise
// - cam-on: fix at once on marker while cam active at low speed
// - cam-on: marker ignored during high-to-low deceleration
// - cam-on: limit after cam handled exactly like cam-off limit case
// - limit-marker: high until limit, reverse low, fix on marker
// - limit-marker: marker already on before limit still fixes after reversal
// - cam-only: reverse high on cam, reverse low on next, fix on third
// - fast-return: high speed straight to stored origin, no switch inputs
// - limit-only: high until limit, reverse low, fix when limit releases
// - marker-only: reverse high, reverse low, fix on third marker
// - marker input ignored once search has fixed the origin
// - deviation-clear output pulses from the same cycle the origin is fixed
module oss_seq #(
	parameter SPD_W   = `OSS_SPD_W,
	parameter ACC_W   = `OSS_ACC_W,
	parameter POS_W   = `OSS_POS_W,
	parameter DCLR_CY = `OSS_DCLR_CYC
) (
	core_clk,
	rst_n,
	clk_en,
	start,
	method,
	dir_fwd,
	hi_speed,
	lo_speed,
	ramp_step,
	origin_pos,
	preset_req,
	preset_pos,
	cam_in,
	marker_in,
	lim_up_in,
	lim_dn_in,
	pulse_out,
	dir_out,
	busy,
	origin_done,
	dev_clr,
	cur_pos,
	err_no_origin
);
	input  wire             core_clk;
	input  wire             rst_n;
	input  wire             clk_en;
	input  wire             start;
	input  wire [2:0]       method;
	input  wire             dir_fwd;
	input  wire [SPD_W-1:0] hi_speed;
	input  wire [SPD_W-1:0] lo_speed;
	input  wire [SPD_W-1:0] ramp_step;
	input  wire [POS_W-1:0] origin_pos;
	input  wire             preset_req;
	input  wire [POS_W-1:0] preset_pos;
	input  wire             cam_in;
	input  wire             marker_in;
	input  wire             lim_up_in;
	input  wire             lim_dn_in;
	output reg              pulse_out;
	output reg              dir_out;
	output reg              busy;
	output reg              origin_done;
	output reg              dev_clr;
	output reg  [POS_W-1:0] cur_pos;
	output reg              err_no_origin;

	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_HI   = 3'h1;
	localparam [2:0] S_SLOW = 3'h2;
	localparam [2:0] S_LO   = 3'h3;
	localparam [2:0] S_REV  = 3'h4;
	localparam [2:0] S_RET  = 3'h5;
	localparam [2:0] S_CLR  = 3'h6;

	localparam integer           DCLR_LAST_I = DCLR_CY - 1;
	localparam [`OSS_DCLR_W-1:0] DCLR_LAST   = DCLR_LAST_I[`OSS_DCLR_W-1:0];

	reg  [2:0]             st_q;
	reg  [2:0]             nxt_q;
	reg  [2:0]             mth_q;
	reg  [SPD_W-1:0]       tgt_q;
	reg  [SPD_W-1:0]       nxt_spd_q;
	reg  [1:0]             ph_q;
	reg                    cam_rel_q;
	reg                    lim_fwd_q;
	reg                    homed_q;
	reg                    halt_q;
	reg  [`OSS_DCLR_W-1:0] dclr_cnt_q;

	wire [SPD_W-1:0] spd;
	wire             at_tgt;
	wire             step_tick;
	wire [3:0]       rise;
	wire [3:0]       fall;
	wire             searching;
	wire             mk_rise;
	wire             lim_ahead;
	wire             lim_rel;
	wire             drive_ok;

	oss_edge #(
		.N(4)
	) u_edge (
		.core_clk(core_clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.sig_in  ({lim_dn_in, lim_up_in, marker_in, cam_in}),
		.rise    (rise),
		.fall    (fall)
	);

	oss_ramp #(
		.SPD_W(SPD_W),
		.ACC_W(ACC_W)
	) u_ramp (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.halt     (halt_q),
		.tgt      (tgt_q),
		.step     (ramp_step),
		.spd      (spd),
		.at_tgt   (at_tgt),
		.step_tick(step_tick)
	);

	// marker only counts while a switch-driven search is running
	assign searching = (st_q == S_HI) || (st_q == S_LO);
	assign mk_rise   = rise[1] & searching;
	assign lim_ahead = dir_out ? lim_up_in : lim_dn_in;
	assign lim_rel   = lim_fwd_q ? fall[2] : fall[3];
	// the ramp still ticks in the fix cycle; a pulse there would leave the drive one step off
	assign drive_ok  = ~halt_q & (st_q != S_IDLE) & (st_q != S_CLR);

	function [POS_W-1:0] pos_step;
		input [POS_W-1:0] p;
		input             fwd;
		begin
			pos_step = fwd ? p + {{(POS_W-1){1'b0}}, 1'b1} : p - {{(POS_W-1){1'b0}}, 1'b1};
		end
	endfunction

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q          <= S_IDLE;
			nxt_q         <= S_IDLE;
			mth_q         <= 3'h0;
			tgt_q         <= {SPD_W{1'b0}};
			nxt_spd_q     <= {SPD_W{1'b0}};
			ph_q          <= 2'h0;
			cam_rel_q     <= 1'b0;
			lim_fwd_q     <= 1'b0;
			homed_q       <= 1'b0;
			halt_q        <= 1'b0;
			dclr_cnt_q    <= {`OSS_DCLR_W{1'b0}};
			pulse_out     <= 1'b0;
			dir_out       <= 1'b0;
			busy          <= 1'b0;
			origin_done   <= 1'b0;
			dev_clr       <= 1'b0;
			cur_pos       <= {POS_W{1'b0}};
			err_no_origin <= 1'b0;
		end
		else if (clk_en)
		begin
			pulse_out <= step_tick & drive_ok;
			if (step_tick && drive_ok)
				cur_pos <= pos_step(cur_pos, dir_out);
			halt_q <= 1'b0;
			case (st_q)
			S_IDLE:
			begin
				busy <= 1'b0;
				if (preset_req)
				begin
					cur_pos <= preset_pos;
					homed_q <= 1'b1;
				end
				else if (start)
				begin
					mth_q       <= method;
					ph_q        <= 2'h0;
					cam_rel_q   <= 1'b0;
					origin_done <= 1'b0;
					err_no_origin <= 1'b0;
					if (method == `OSS_M_FAST_RET)
					begin
						// refuse without a known origin
						if (!homed_q)
							err_no_origin <= 1'b1;
						else if (cur_pos == origin_pos)
						begin
							busy <= 1'b1;
							st_q <= S_CLR;
						end
						else
						begin
							// no switch inputs used on this path
							busy    <= 1'b1;
							dir_out <= ($signed(origin_pos) > $signed(cur_pos));
							tgt_q   <= hi_speed;
							st_q    <= S_RET;
						end
					end
					else
					begin
						busy    <= 1'b1;
						dir_out <= dir_fwd;
						tgt_q   <= hi_speed;
						st_q    <= S_HI;
					end
				end
			end
			S_HI:
			begin
				case (mth_q)
				`OSS_M_CAM_OFF, `OSS_M_CAM_ON:
				begin
					if (rise[0])
					begin
						tgt_q <= lo_speed;
						st_q  <= S_SLOW;
					end
					else if (lim_ahead)
					begin
						tgt_q     <= {SPD_W{1'b0}};
						nxt_spd_q <= hi_speed;
						nxt_q     <= S_HI;
						st_q      <= S_REV;
					end
				end
				`OSS_M_LIM_MARK, `OSS_M_LIM_ONLY:
				begin
					if (lim_ahead)
					begin
						lim_fwd_q <= dir_out;
						tgt_q     <= {SPD_W{1'b0}};
						nxt_spd_q <= lo_speed;
						nxt_q     <= S_LO;
						st_q      <= S_REV;
					end
				end
				`OSS_M_CAM_ONLY, `OSS_M_MARK_ONLY:
				begin
					if ((mth_q == `OSS_M_CAM_ONLY) ? rise[0] : mk_rise)
					begin
						tgt_q     <= {SPD_W{1'b0}};
						nxt_spd_q <= (ph_q == 2'h0) ? hi_speed : lo_speed;
						nxt_q     <= (ph_q == 2'h0) ? S_HI : S_LO;
						ph_q      <= ph_q + 2'h1;
						st_q      <= S_REV;
					end
					else if (lim_ahead)
					begin
						tgt_q     <= {SPD_W{1'b0}};
						nxt_spd_q <= hi_speed;
						nxt_q     <= S_HI;
						st_q      <= S_REV;
					end
				end
				default:
					st_q <= S_IDLE;
				endcase
			end
			S_SLOW:
			begin
				// marker edges are deliberately dropped until low speed is reached
				if (rise[0] == 1'b0 && fall[0])
					cam_rel_q <= 1'b1;
				if (at_tgt)
					st_q <= S_LO;
			end
			S_LO:
			begin
				if (fall[0])
					cam_rel_q <= 1'b1;
				else if (rise[0])
					cam_rel_q <= 1'b0;
				case (mth_q)
				`OSS_M_CAM_OFF:
				begin
					if (mk_rise && cam_rel_q && !cam_in)
						st_q <= S_CLR;
				end
				`OSS_M_CAM_ON:
				begin
					if (mk_rise && cam_in)
						st_q <= S_CLR;
				end
				`OSS_M_LIM_MARK:
				begin
					// level test lets a marker already on fix the origin
					if (marker_in)
						st_q <= S_CLR;
				end
				`OSS_M_LIM_ONLY:
				begin
					if (lim_rel)
						st_q <= S_CLR;
				end
				`OSS_M_CAM_ONLY:
				begin
					if (rise[0])
						st_q <= S_CLR;
				end
				`OSS_M_MARK_ONLY:
				begin
					if (mk_rise)
						st_q <= S_CLR;
				end
				default:
					st_q <= S_IDLE;
				endcase
				// cam-off/cam-on limit while awaiting the final edge: turn back at low speed
				if ((mth_q == `OSS_M_CAM_OFF || mth_q == `OSS_M_CAM_ON) && lim_ahead)
				begin
					tgt_q     <= {SPD_W{1'b0}};
					nxt_spd_q <= lo_speed;
					nxt_q     <= S_LO;
					st_q      <= S_REV;
				end
			end
			S_REV:
			begin
				if (spd == {SPD_W{1'b0}})
				begin
					dir_out <= ~dir_out;
					tgt_q   <= nxt_spd_q;
					st_q    <= (nxt_q == S_LO) ? S_SLOW : nxt_q;
				end
			end
			S_RET:
			begin
				// no deceleration ramp: stops dead on the origin count
				if (cur_pos == origin_pos || pos_step(cur_pos, dir_out) == origin_pos && step_tick)
					st_q <= S_CLR;
			end
			S_CLR:
			begin
				if (dev_clr == 1'b0 && origin_done == 1'b0)
				begin
					halt_q      <= 1'b1;
					tgt_q       <= {SPD_W{1'b0}};
					cur_pos     <= origin_pos;
					homed_q     <= 1'b1;
					origin_done <= 1'b1;
					dev_clr     <= 1'b1;
					dclr_cnt_q  <= {`OSS_DCLR_W{1'b0}};
				end
				else if (dclr_cnt_q == DCLR_LAST)
				begin
					dev_clr <= 1'b0;
					busy    <= 1'b0;
					st_q    <= S_IDLE;
				end
				else
				begin
					halt_q     <= 1'b1;
					dclr_cnt_q <= dclr_cnt_q + {{(`OSS_DCLR_W-1){1'b0}}, 1'b1};
				end
			end
			default:
				st_q <= S_IDLE;
			endcase
		end
	end
endmodule // oss_seq

// ==== src/oss_defs.vh ====
`ifndef OSS_DEFS_VH
`define OSS_DEFS_VH

// search method codes on the method input
`define OSS_M_CAM_OFF    3'h0
`define OSS_M_CAM_ON     3'h1
`define OSS_M_LIM_MARK   3'h2
`define OSS_M_CAM_ONLY   3'h3
`define OSS_M_FAST_RET   3'h4
`define OSS_M_LIM_ONLY   3'h5
`define OSS_M_MARK_ONLY  3'h6

// timing
`define OSS_CLK_NS       50
`define OSS_DCLR_NS      10000
`define OSS_DCLR_CYC     ((`OSS_DCLR_NS + `OSS_CLK_NS - 1) / `OSS_CLK_NS)

// bus and counter widths
`define OSS_SPD_W        16
`define OSS_ACC_W        20
`define OSS_POS_W        32
`define OSS_DCLR_W       12

`endif

// ==== src/oss_edge.v ====
`timescale 1ns/1ps
module oss_edge #(
	parameter N = 4
) (
	core_clk,
	rst_n,
	clk_en,
	sig_in,
	rise,
	fall
);
	input  wire         core_clk;
	input  wire         rst_n;
	input  wire         clk_en;
	input  wire [N-1:0] sig_in;
	output wire [N-1:0] rise;
	output wire [N-1:0] fall;

	reg [N-1:0] prev_q;

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			prev_q <= {N{1'b0}};
		else if (clk_en)
			prev_q <= sig_in;
	end

	assign rise = sig_in & ~prev_q;
	assign fall = ~sig_in & prev_q;
endmodule // oss_edge

// ==== src/oss_ramp.v ====
`timescale 1ns/1ps
module oss_ramp #(
	parameter SPD_W = 16,
	parameter ACC_W = 20
) (
	core_clk,
	rst_n,
	clk_en,
	halt,
	tgt,
	step,
	spd,
	at_tgt,
	step_tick
);
	input  wire             core_clk;
	input  wire             rst_n;
	input  wire             clk_en;
	input  wire             halt;
	input  wire [SPD_W-1:0] tgt;
	input  wire [SPD_W-1:0] step;
	output reg  [SPD_W-1:0] spd;
	output wire             at_tgt;
	output wire             step_tick;

	reg  [ACC_W-1:0] acc_q;
	wire [ACC_W:0]   acc_sum;
	wire [SPD_W:0]   up;

	assign acc_sum   = {1'b0, acc_q} + {{(ACC_W-SPD_W+1){1'b0}}, spd};
	assign step_tick = clk_en & acc_sum[ACC_W];
	assign at_tgt    = (spd == tgt);
	assign up        = {1'b0, spd} + {1'b0, step};

	// speed moves by step per cycle, or to zero at once on halt, and never overshoots the target
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			spd   <= {SPD_W{1'b0}};
			acc_q <= {ACC_W{1'b0}};
		end
		else if (clk_en)
		begin
			acc_q <= acc_sum[ACC_W-1:0];
			if (halt)
				spd <= {SPD_W{1'b0}};
			else if (spd < tgt)
				spd <= (up[SPD_W] || up[SPD_W-1:0] > tgt) ? tgt : up[SPD_W-1:0];
			else if (spd > tgt)
				spd <= (spd - tgt < step) ? tgt : spd - step;
		end
	end
endmodule // oss_ramp

// ==== test/oss_plant.sv ====
`timescale 1ns/1ps
module oss_plant #(
	parameter LIM = 116
) (
	input  wire    core_clk,
	input  wire    pulse_out,
	input  wire    dir_out,
	input  wire    load,
	input  integer cam_hi,
	output integer pos,
	output wire    cam_in,
	output wire    marker_in,
	output wire    lim_up_in,
	output wire    lim_dn_in
);
	initial pos = 0;
	always @(posedge core_clk)
		if (load)
			pos <= 0;
		else if (pulse_out)
			pos <= dir_out ? pos + 1 : pos - 1;
	assign cam_in = pos >= 40 && pos <= cam_hi;
	// two positions wide so even high speed leaves it up for many cycles
	assign marker_in = pos % 16 == 4 || pos % 16 == 5;
	assign lim_up_in = pos >= LIM;
	assign lim_dn_in = pos <= -LIM;
endmodule // oss_plant

// ==== test/oss_seq_sva.sv ====
`timescale 1ns/1ps
module oss_seq_sva #(
	parameter POS_W = 32
) (
	input wire logic             core_clk,
	input wire logic             rst_n,
	input wire logic             clk_en,
	input wire logic             start,
	input wire logic [2:0]       method,
	input wire logic             preset_req,
	input wire logic [POS_W-1:0] origin_pos,
	input wire logic             cam_in,
	input wire logic             lim_up_in,
	input wire logic             lim_dn_in,
	input wire logic             pulse_out,
	input wire logic             busy,
	input wire logic             origin_done,
	input wire logic             dev_clr,
	input wire logic [POS_W-1:0] cur_pos,
	input wire logic             err_no_origin
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_RUN_BUSY: assert property (pulse_out |-> busy)
		else $error("pulse while idle");
	AST_START: assert property (clk_en && !busy && start && !preset_req && method != 3'h4 |=> busy)
		else $error("start not taken");
	AST_CLR_ON_FIX: assert property ($rose(origin_done) |-> dev_clr)
		else $error("no deviation clear at fix");
	AST_CLR_LEN: assert property ($rose(dev_clr) |-> dev_clr [*4])
		else $error("deviation clear too short");
	AST_FIX_POS: assert property ($rose(origin_done) |-> cur_pos == origin_pos)
		else $error("position not loaded at fix");
	AST_HALT: assert property (origin_done && busy |-> !pulse_out)
		else $error("pulse after fix");
	AST_CAM_OFF: assert property ($rose(origin_done) && method == 3'h0 |-> !$past(cam_in))
		else $error("fix with cam active");
	AST_CAM_ON: assert property ($rose(origin_done) && method == 3'h1 |-> $past(cam_in))
		else $error("fix without cam");
	AST_LIM_ONLY: assert property ($rose(origin_done) && method == 3'h5 |-> !$past(lim_up_in) && !$past(lim_dn_in))
		else $error("fix with limit active");
	AST_ERR: assert property (err_no_origin |-> !busy && !origin_done)
		else $error("refused return moved");
	cover property ($rose(origin_done) && method == 3'h3);
	cover property ($rose(err_no_origin));
	cover property ($fell(busy) && method == 3'h4);
endmodule // oss_seq_sva
bind oss_seq oss_seq_sva #(.POS_W(POS_W)) oss_seq_sva_i (
	.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .start(start),
	.method(method), .preset_req(preset_req), .origin_pos(origin_pos),
	.cam_in(cam_in), .lim_up_in(lim_up_in), .lim_dn_in(lim_dn_in),
	.pulse_out(pulse_out), .busy(busy), .origin_done(origin_done),
	.dev_clr(dev_clr), .cur_pos(cur_pos), .err_no_origin(err_no_origin)
);

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	reg        core_clk = 0;
	reg        rst_n = 0;
	reg        start = 0;
	reg        preset_req = 0;
	reg        load = 0;
	reg        done_q = 0;
	reg        clk_en = 1;
	reg        dir_fwd = 1;
	reg [2:0]  method = 0;
	reg [3:0]  seen_q = 0;
	reg [31:0] origin_pos = 0;
	reg [31:0] preset_pos = 0;
	integer    cam_hi = 80;
	integer    failures = 0;
	integer    n_compared = 0;
	integer    cyc = 0;
	integer    i;
	wire       pulse_out, dir_out, busy, origin_done, dev_clr, err_no_origin;
	wire       cam_in, marker_in, lim_up_in, lim_dn_in;
	wire [31:0] cur_pos, pos;
	oss_seq #(.DCLR_CY(4)) oss_seq_i (
		.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .start(start),
		.method(method), .dir_fwd(dir_fwd), .hi_speed(16'hffff), .lo_speed(16'h4000),
		.ramp_step(16'h0400), .origin_pos(origin_pos), .preset_req(preset_req),
		.preset_pos(preset_pos), .cam_in(cam_in), .marker_in(marker_in),
		.lim_up_in(lim_up_in), .lim_dn_in(lim_dn_in), .pulse_out(pulse_out),
		.dir_out(dir_out), .busy(busy), .origin_done(origin_done), .dev_clr(dev_clr),
		.cur_pos(cur_pos), .err_no_origin(err_no_origin)
	);
	oss_plant oss_plant_i (
		.core_clk(core_clk), .pulse_out(pulse_out), .dir_out(dir_out), .load(load),
		.cam_hi(cam_hi), .pos(pos), .cam_in(cam_in), .marker_in(marker_in),
		.lim_up_in(lim_up_in), .lim_dn_in(lim_dn_in)
	);
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 60000)
		begin
			failures = failures + 1;
			complete_run;
		end
	end
	// switch picture at the fix: cam, marker, limit, direction
	always @(negedge core_clk)
	begin
		if (origin_done && !done_q)
			seen_q <= {cam_in, marker_in, lim_up_in | lim_dn_in, dir_out};
		done_q <= origin_done;
	end
	function [3:0] exp_fix(input [2:0] m);
		case (m)
			3'h1: exp_fix = 4'b1101;
			3'h2: exp_fix = 4'b0110;
			3'h3: exp_fix = 4'b1001;
			3'h5: exp_fix = 4'b0000;
			default: exp_fix = 4'b0101;
		endcase
	endfunction
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp)
			begin
				failures = failures + 1;
				$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task run(input [2:0] m);
		begin
			@(negedge core_clk);
			load = 1;
			@(negedge core_clk);
			load = 0;
			method = m;
			start = 1;
			@(negedge core_clk);
			start = 0;
			i = 0;
			while (busy !== 1'b0 && i < 20000)
			begin
				@(negedge core_clk);
				i = i + 1;
			end
		end
	endtask
	task search(input [2:0] m);
		begin
			origin_pos = $urandom;
			// a one-position cam makes each pass a fresh rising edge
			cam_hi = m == 3'h3 ? 40 : 80;
			run(m);
			chk("done", origin_done, 1);
			chk("cur_pos", cur_pos, origin_pos);
			chk("dev_clr", dev_clr, 0);
			$display("test method %0d finished", m);
		end
	endtask
	task complete_run;
		begin
			$display("compared %0d failures %0d", n_compared, failures);
			if (failures == 0 && n_compared > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial
	begin
		i = $urandom(52338);
		repeat (10) @(negedge core_clk);
		rst_n = 1;
		run(3'h4);
		chk("no_origin", err_no_origin, 1);
		// a start while frozen must not be taken, nor clear the refusal flag
		@(negedge core_clk);
		clk_en = 0;
		method = 3'h0;
		start = 1;
		repeat (3) @(negedge core_clk);
		start = 0;
		clk_en = 1;
		chk("frozen_busy", busy, 0);
		chk("frozen_err", err_no_origin, 1);
		search(3'h0);
		chk("cam_off", seen_q, exp_fix(3'h0));
		search(3'h1);
		chk("cam_on", seen_q, exp_fix(3'h1));
		search(3'h2);
		chk("lim_mark", seen_q, exp_fix(3'h2));
		search(3'h3);
		chk("cam_only", seen_q, exp_fix(3'h3));
		search(3'h5);
		chk("lim_only", seen_q, exp_fix(3'h5));
		// reverse search: lower limit, turn back forward, fix as it releases
		dir_fwd = 0;
		search(3'h5);
		chk("lim_only_rev", seen_q, 4'b0001);
		dir_fwd = 1;
		search(3'h6);
		chk("mark_only", seen_q, exp_fix(3'h6));
		preset_pos = $urandom;
		@(negedge core_clk);
		preset_req = 1;
		@(negedge core_clk);
		preset_req = 0;
		chk("preset", cur_pos, preset_pos);
		origin_pos = preset_pos + $urandom % 61 - 30;
		run(3'h4);
		chk("ret_pos", cur_pos, origin_pos);
		chk("ret_steps", pos, origin_pos - preset_pos);
		chk("ret_err", err_no_origin, 0);
		$display("test fast return finished");
		complete_run;
	end
endmodule // tb_top
